/* design/timer_buffered_pwm_control.sv */
// Four-channel 16-bit timer with buffered PWM pairs and flag logic.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module timer_buffered_pwm_control
    import pwm_timer_pkg::*;
#(
    parameter int CHANNELS = 4
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [4:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [7:0] read_data,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic break_active,
    input wire logic break_clear_enable,
    input wire logic external_count_clock_pin,
    output logic external_clock_selected,
    input wire logic [CHANNELS-1:0] channel_pin_in,
    output logic [CHANNELS-1:0] channel_pin_out,
    output logic [CHANNELS-1:0] channel_pin_oe,
    output logic irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0] counter;
        logic [PRESCALE_WIDTH-1:0] prescaler;
        logic [15:0] modulo;
        logic modulo_hold;
        logic overflow_flag;
        logic overflow_armed;
        logic overflow_irq_enable;
        logic counter_halt;
        logic [2:0] prescale_select;
        logic [7:0] count_low_latch;
        logic count_latched;
        logic [CHANNELS-1:0][6:0] channel_ctrl;
        logic [CHANNELS-1:0] channel_event_flag;
        logic [CHANNELS-1:0] channel_armed;
        logic [CHANNELS-1:0][15:0] compare;
        logic [CHANNELS-1:0] level;
        logic [CHANNELS-1:0] pin_prev;
        logic [CHANNELS-1:0] pin_oe;
        logic [1:0] last_written;
        logic [1:0] active_set;
        logic ext_sync1;
        logic ext_sync2;
        logic ext_prev;
        logic [7:0] read_data;
        logic irq;
        logic ext_selected;
    } state_type;

    state_type state;
    state_type next_state;

    logic access_write;
    logic access_read;
    logic clear_allowed;
    logic run;
    logic tick;
    logic overflow_event;
    logic [15:0] count_next;
    logic [PRESCALE_WIDTH-1:0] prescale_mask;
    logic [CHANNELS-1:0] channel_event;

    // ************************************************************
    // Next-state logic
    // ************************************************************

    // One process computes the whole next state so that event and
    // clear decisions in the same cycle are resolved in one place.
    always_comb
    begin
        next_state = state;
        channel_event = '0;
        // Wait mode locks the CPU out of the registers entirely.
        access_write = write_strobe && !wait_mode;
        access_read = read_strobe && !wait_mode;
        // Without break-clear enable a break blocks the clearing of every flag.
        clear_allowed = !break_active || break_clear_enable;
        next_state.read_data = 8'h00;

        // Synchroniser; only the second stage feeds the edge detector.
        next_state.ext_sync1 = external_count_clock_pin;
        next_state.ext_sync2 = state.ext_sync1;
        next_state.ext_prev = state.ext_sync2;
        next_state.ext_selected =
            (state.prescale_select == PRESCALE_EXTERNAL);

        // Counter source: divided bus clock or external rising edge.
        run = !state.counter_halt && !stop_mode && !break_active;
        prescale_mask = PRESCALE_WIDTH'((7'h01 << state.prescale_select)
            - 7'h01);
        if (state.prescale_select == PRESCALE_EXTERNAL)
        begin
            tick = run && state.ext_sync2 && !state.ext_prev;
        end
        else
        begin
            tick = run && ((state.prescaler & prescale_mask)
                == prescale_mask);
        end
        if (run)
        begin
            next_state.prescaler = state.prescaler + 1'b1;
        end
        overflow_event = tick && (state.counter == state.modulo);
        count_next = overflow_event ? 16'h0000 : state.counter + 16'h0001;
        if (tick)
        begin
            next_state.counter = count_next;
        end

        // Overflow flag: hardware set wins over a clear in the same cycle.
        if (access_read && address == ADDR_STATUS_CONTROL)
        begin
            next_state.read_data = {state.overflow_flag,
                state.overflow_irq_enable, state.counter_halt, 2'b00,
                state.prescale_select};
            if (state.overflow_flag && clear_allowed)
            begin
                next_state.overflow_armed = 1'b1;
            end
        end
        if (access_write && address == ADDR_STATUS_CONTROL)
        begin
            next_state.overflow_irq_enable = write_data[TSC_OVERFLOW_IRQ_ENABLE];
            next_state.counter_halt = write_data[TSC_COUNTER_HALT];
            next_state.prescale_select =
                write_data[TSC_PRESCALE_MSB -: 3];
            if (!write_data[TSC_OVERFLOW_FLAG] && state.overflow_armed
                && clear_allowed)
            begin
                next_state.overflow_flag = 1'b0;
                next_state.overflow_armed = 1'b0;
            end
            // Counter reset is a write-only action; it is never stored.
            if (write_data[TSC_COUNTER_RESET])
            begin
                next_state.counter = 16'h0000;
                next_state.prescaler = '0;
            end
        end
        if (overflow_event && !state.modulo_hold)
        begin
            next_state.overflow_flag = 1'b1;
            next_state.overflow_armed = 1'b0;
        end

        // Count registers: reading the high byte freezes the low byte.
        if (access_read && address == ADDR_COUNT_HIGH)
        begin
            next_state.read_data = state.counter[15:8];
            next_state.count_low_latch = state.counter[7:0];
            next_state.count_latched = 1'b1;
        end
        if (access_read && address == ADDR_COUNT_LOW)
        begin
            next_state.read_data = state.count_latched
                ? state.count_low_latch : state.counter[7:0];
            next_state.count_latched = 1'b0;
        end

        // Modulo: a high-byte write holds off overflow flagging until low.
        if (access_read && address == ADDR_MODULO_HIGH)
        begin
            next_state.read_data = state.modulo[15:8];
        end
        if (access_read && address == ADDR_MODULO_LOW)
        begin
            next_state.read_data = state.modulo[7:0];
        end
        if (access_write && address == ADDR_MODULO_HIGH)
        begin
            next_state.modulo[15:8] = write_data;
            next_state.modulo_hold = 1'b1;
        end
        if (access_write && address == ADDR_MODULO_LOW)
        begin
            next_state.modulo[7:0] = write_data;
            next_state.modulo_hold = 1'b0;
        end

        // At every overflow the pair's most recently written set takes over.
        for (int p = 0; p < 2; p++)
        begin
            if (!state.channel_ctrl[2*p][CSC_MODE_SELECT_B])
            begin
                next_state.active_set[p] = 1'b0;
            end
            else if (overflow_event)
            begin
                next_state.active_set[p] = state.last_written[p];
            end
        end

        // Per-channel register access, capture, compare and pin level.
        for (int c = 0; c < CHANNELS; c++)
        begin
            logic [4:0] base;
            logic partner_linked;
            logic linked;
            logic output_mode;
            logic [1:0] edge_level;
            logic [15:0] compare_value;
            logic rising;
            logic falling;
            base = 5'(ADDR_CHANNEL_BASE + ADDR_CHANNEL_STRIDE * 5'(c));
            // Odd channels are swallowed when their even partner links.
            partner_linked = (c % 2 == 1)
                && state.channel_ctrl[c-(c%2)][CSC_MODE_SELECT_B];
            linked = (c % 2 == 0)
                && state.channel_ctrl[c][CSC_MODE_SELECT_B];
            // The buffer-link bit decides before mode bit A is looked at.
            output_mode = linked
                || state.channel_ctrl[c][CSC_MODE_SELECT_A];
            edge_level = state.channel_ctrl[c][CSC_EDGE_LEVEL_MSB -: 2];
            compare_value = linked
                ? state.compare[c + int'(state.active_set[c/2])]
                : state.compare[c];
            rising = channel_pin_in[c] && !state.pin_prev[c];
            falling = !channel_pin_in[c] && state.pin_prev[c];
            next_state.pin_prev[c] = channel_pin_in[c];

            if (access_read && address == base)
            begin
                next_state.read_data = partner_linked ? 8'h00
                    : {state.channel_event_flag[c], state.channel_ctrl[c]};
                if (state.channel_event_flag[c] && clear_allowed)
                begin
                    next_state.channel_armed[c] = 1'b1;
                end
            end
            if (access_write && address == base && !partner_linked)
            begin
                next_state.channel_ctrl[c] = write_data[6:0];
                if ((c % 2) == 1)
                begin
                    next_state.channel_ctrl[c][CSC_MODE_SELECT_B] = 1'b0;
                end
                if (!write_data[CSC_EVENT_FLAG] && state.channel_armed[c]
                    && clear_allowed)
                begin
                    next_state.channel_event_flag[c] = 1'b0;
                    next_state.channel_armed[c] = 1'b0;
                end
            end
            if (access_read && address == base + 5'h01)
            begin
                next_state.read_data = state.compare[c][15:8];
            end
            if (access_read && address == base + 5'h02)
            begin
                next_state.read_data = state.compare[c][7:0];
            end
            if (access_write && address == base + 5'h01)
            begin
                next_state.compare[c][15:8] = write_data;
            end
            if (access_write && address == base + 5'h02)
            begin
                next_state.compare[c][7:0] = write_data;
            end
            // Remember which set of the pair software touched last.
            if (access_write && (address == base + 5'h01
                || address == base + 5'h02))
            begin
                next_state.last_written[c/2] = (c % 2 == 1);
            end

            if (!partner_linked && !stop_mode)
            begin
                if (!output_mode && edge_level != EDGE_LEVEL_NONE)
                begin
                    // Input capture on the selected edge.
                    if ((edge_level == CAPTURE_RISING && rising)
                        || (edge_level == CAPTURE_FALLING && falling)
                        || (edge_level == EDGE_LEVEL_SET
                        && (rising || falling)))
                    begin
                        channel_event[c] = 1'b1;
                        next_state.compare[c] = state.counter;
                    end
                end
                else if (output_mode)
                begin
                    if (edge_level == EDGE_LEVEL_NONE)
                    begin
                        // Timer does not own the pin; preset the level.
                        next_state.level[c] =
                            !state.channel_ctrl[c][CSC_MODE_SELECT_A];
                    end
                    else if (state.channel_ctrl[c][CSC_FULL_DUTY_FORCE]
                        && !state.channel_ctrl[c][CSC_TOGGLE_AT_OVERFLOW])
                    begin
                        next_state.level[c] = 1'b1;
                    end
                    else if (overflow_event
                        && state.channel_ctrl[c][CSC_TOGGLE_AT_OVERFLOW])
                    begin
                        // Without the toggle or full-duty bit the level is left alone,
                        // so the clearing compare keeps it low: 0% duty.
                        next_state.level[c] = !state.level[c];
                    end
                    if (tick && count_next == compare_value)
                    begin
                        channel_event[c] = 1'b1;
                        if (edge_level == EDGE_LEVEL_CLEAR)
                        begin
                            next_state.level[c] = 1'b0;
                        end
                        else if (edge_level == EDGE_LEVEL_SET)
                        begin
                            next_state.level[c] = 1'b1;
                        end
                        else if (edge_level == EDGE_LEVEL_TOGGLE)
                        begin
                            next_state.level[c] = !state.level[c];
                        end
                    end
                    // Full duty outranks a compare match, so a match at
                    // rollover cannot cut a one-cycle low glitch.
                    if (state.channel_ctrl[c][CSC_FULL_DUTY_FORCE]
                        && !state.channel_ctrl[c][CSC_TOGGLE_AT_OVERFLOW]
                        && edge_level != EDGE_LEVEL_NONE)
                    begin
                        next_state.level[c] = 1'b1;
                    end
                end
            end
            // An event landing with the clearing write still sets the flag.
            if (channel_event[c])
            begin
                next_state.channel_event_flag[c] = 1'b1;
                next_state.channel_armed[c] = 1'b0;
            end
            next_state.pin_oe[c] = !partner_linked && output_mode
                && edge_level != EDGE_LEVEL_NONE;
        end

        // Interrupt request, gated by the overflow and channel enables.
        next_state.irq = (next_state.overflow_flag
            && next_state.overflow_irq_enable);
        for (int c = 0; c < CHANNELS; c++)
        begin
            if (next_state.channel_event_flag[c]
                && next_state.channel_ctrl[c][CSC_IRQ_ENABLE])
            begin
                next_state.irq = 1'b1;
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************

    // Counter halt is set at reset so nothing counts until software
    // has loaded the period and compare values.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= '0;
            state.counter_halt <= 1'b1;
            state.modulo <= MODULO_RESET;
            state.channel_ctrl <= {CHANNELS{CHANNEL_CTRL_RESET}};
        end
        else
        begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // All outputs are taken straight from state flip-flops.
    assign read_data = state.read_data;
    assign external_clock_selected = state.ext_selected;
    assign channel_pin_out = state.level;
    assign channel_pin_oe = state.pin_oe;
    assign irq = state.irq;

endmodule // timer_buffered_pwm_control
`default_nettype wire

/* inc/pwm_timer_pkg.sv */
// Shared constants for the four-channel buffered PWM timer.
package pwm_timer_pkg;

    // ************************************************************
    // Register map (byte registers, 5-bit address)
    // ************************************************************
    localparam logic [4:0] ADDR_STATUS_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_COUNT_HIGH = 5'h01;
    localparam logic [4:0] ADDR_COUNT_LOW = 5'h02;
    localparam logic [4:0] ADDR_MODULO_HIGH = 5'h03;
    localparam logic [4:0] ADDR_MODULO_LOW = 5'h04;
    // Channel c: status/control at base+3c, compare high +1, low +2.
    localparam logic [4:0] ADDR_CHANNEL_BASE = 5'h05;
    localparam logic [4:0] ADDR_CHANNEL_STRIDE = 5'h03;

    // ************************************************************
    // Timer status/control fields
    // ************************************************************
    localparam int TSC_OVERFLOW_FLAG = 7;
    localparam int TSC_OVERFLOW_IRQ_ENABLE = 6;
    localparam int TSC_COUNTER_HALT = 5;
    localparam int TSC_COUNTER_RESET = 4;
    localparam int TSC_PRESCALE_MSB = 2;

    // ************************************************************
    // Channel status/control fields
    // ************************************************************
    localparam int CSC_EVENT_FLAG = 7;
    localparam int CSC_IRQ_ENABLE = 6;
    localparam int CSC_MODE_SELECT_B = 5;
    localparam int CSC_MODE_SELECT_A = 4;
    localparam int CSC_EDGE_LEVEL_MSB = 3;
    localparam int CSC_TOGGLE_AT_OVERFLOW = 1;
    localparam int CSC_FULL_DUTY_FORCE = 0;

    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [2:0] PRESCALE_EXTERNAL = 3'h7;
    localparam logic [1:0] EDGE_LEVEL_NONE = 2'h0;
    localparam logic [1:0] EDGE_LEVEL_TOGGLE = 2'h1;
    localparam logic [1:0] EDGE_LEVEL_CLEAR = 2'h2;
    localparam logic [1:0] EDGE_LEVEL_SET = 2'h3;
    localparam logic [1:0] CAPTURE_RISING = 2'h1;
    localparam logic [1:0] CAPTURE_FALLING = 2'h2;
    localparam logic [15:0] MODULO_RESET = 16'hffff;
    localparam logic [6:0] CHANNEL_CTRL_RESET = 7'h00;
    localparam int PRESCALE_WIDTH = 6;

endpackage

/* tb/pin_env.sv */
// Pin-side model for the channel pins and the external count clock.
`timescale 1ns/1ns
`default_nettype none
module pin_env (
    input wire logic clock,
    input wire logic [3:0] channel_pin_out,
    input wire logic [3:0] channel_pin_oe,
    input wire logic [3:0] gpio_level,
    output logic [3:0] channel_pin_in,
    output logic external_count_clock_pin
);
    // A released pin shows the port level, never a stale timer value.
    assign channel_pin_in = (channel_pin_oe & channel_pin_out) |
        (~channel_pin_oe & gpio_level);
    initial external_count_clock_pin = 1'b0;
    // Pulses last three cycles so the synchroniser cannot miss them.
    task automatic ext_pulses(input int n);
        repeat (n)
        begin
            @(posedge clock);
            external_count_clock_pin <= 1'b1;
            repeat (3) @(posedge clock);
            external_count_clock_pin <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask
endmodule // pin_env
`default_nettype wire

/* tb/pwm_timer_monitor.sv */
// Port assertions for the buffered PWM timer.
`timescale 1ns/1ns
`default_nettype none
module pwm_timer_monitor #(
    parameter int CHANNELS = 4
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [4:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [7:0] read_data,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic external_clock_selected,
    input wire logic [CHANNELS-1:0] channel_pin_out,
    input wire logic [CHANNELS-1:0] channel_pin_oe
);
    logic link_low;
    logic link_high;
    logic [2:0] ps;
    logic ps_ext;
    assign ps_ext = (ps == 3'h7);
    // Shadow the link bits and prescale code from accepted writes.
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
        begin
            link_low <= 1'b0;
            link_high <= 1'b0;
            ps <= 3'h0;
        end
        else if (write_strobe && !wait_mode)
        begin
            if (address == 5'h05) link_low <= write_data[5];
            if (address == 5'h0b) link_high <= write_data[5];
            if (address == 5'h00) ps <= write_data[2:0];
        end
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_read_blocked_zero: assert property (!$past(read_strobe) ||
        $past(wait_mode) |-> read_data == 8'h00) else $error("read leak");
    a_count_reset_bit: assert property ($past(read_strobe) &&
        !$past(wait_mode) && $past(address) == 5'h00 |-> !read_data[4])
        else $error("counter reset bit read as one");
    a_odd_low_status: assert property ($past(read_strobe) &&
        !$past(wait_mode) && $past(address) == 5'h08 && $past(link_low)
        |-> read_data == 8'h00) else $error("linked ch1 status read");
    a_odd_high_status: assert property ($past(read_strobe) &&
        !$past(wait_mode) && $past(address) == 5'h0e && $past(link_high)
        |-> read_data == 8'h00) else $error("linked ch3 status read");
    a_low_pin_release: assert property (link_low && $past(link_low, 2)
        |-> !channel_pin_oe[1]) else $error("ch1 pin driven while linked");
    a_high_pin_release: assert property (link_high &&
        $past(link_high, 2) |-> !channel_pin_oe[3])
        else $error("ch3 pin driven while linked");
    a_ext_clock_on: assert property (ps_ext && $past(ps_ext)
        |-> external_clock_selected) else $error("external clock not taken");
    a_ext_clock_off: assert property (!ps_ext && $past(!ps_ext)
        |-> !external_clock_selected) else $error("external clock taken");
    a_stop_pins_frozen: assert property (stop_mode && $past(stop_mode) &&
        $past(stop_mode, 2) && !$past(write_strobe) |-> $stable(channel_pin_out))
        else $error("pin changed in stop");
endmodule // pwm_timer_monitor
bind timer_buffered_pwm_control pwm_timer_monitor #(.CHANNELS(CHANNELS)) mon (
    .clock, .arst_n, .address, .write_data, .write_strobe, .read_strobe,
    .read_data, .wait_mode, .stop_mode, .external_clock_selected,
    .channel_pin_out, .channel_pin_oe);
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the buffered PWM timer.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] address = 5'h00;
    logic [7:0] write_data = 8'h00;
    logic write_strobe = 1'b0;
    logic read_strobe = 1'b0;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic break_active = 1'b0;
    logic break_clear_enable = 1'b0;
    logic [3:0] gpio_level = 4'hf;
    logic [7:0] read_data, got;
    logic external_count_clock_pin, external_clock_selected, irq;
    logic [3:0] channel_pin_in, channel_pin_out, channel_pin_oe;
    logic [15:0] high_count;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    always #25 clock = ~clock;
    timer_buffered_pwm_control dut (.clock, .arst_n, .address, .write_data,
        .write_strobe, .read_strobe, .read_data, .wait_mode, .stop_mode,
        .break_active, .break_clear_enable, .external_count_clock_pin,
        .external_clock_selected, .channel_pin_in, .channel_pin_out,
        .channel_pin_oe, .irq);
    pin_env env (.clock, .channel_pin_out, .channel_pin_oe, .gpio_level,
        .channel_pin_in, .external_count_clock_pin);
    // ************************************************************
    // Bus tasks and comparisons
    // ************************************************************
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    task automatic rd_get(input logic [4:0] a, output logic [7:0] v);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        @(negedge clock);
        v = read_data;
        // Return on a rising edge so callers drive inputs there.
        @(posedge clock);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        rd_get(a, got);
        chk(16'(got), 16'(e));
    endtask
    // Counting over two whole periods makes the result phase-independent.
    task automatic duty(input int idx, input logic [15:0] e);
        repeat (30) @(posedge clock);
        high_count = 16'h0000;
        repeat (20)
        begin
            @(negedge clock);
            if (channel_pin_out[idx] === 1'b1) high_count = high_count + 1'b1;
        end
        chk(high_count, e);
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // A hang counts as a mismatch and ends the run.
    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    // ************************************************************
    // Test sequence
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        rd(5'h00, 8'h20);
        rd(5'h03, 8'hff);
        rd(5'h1f, 8'h00);
        $display("reset values done");
        wr(5'h00, 8'h30);
        wr(5'h03, 8'h00);
        wr(5'h04, 8'h09);
        wr(5'h06, 8'h00);
        wr(5'h07, 8'h04);
        wr(5'h05, 8'h3a);
        wr(5'h09, 8'h00);
        wr(5'h0a, 8'h07);
        wr(5'h00, 8'h40);
        duty(0, 16'h000e);
        chk(16'(channel_pin_oe[1:0]), 16'h0001);
        rd(5'h08, 8'h00);
        wr(5'h07, 8'h02);
        duty(0, 16'h0004);
        wr(5'h0b, 8'h39);
        duty(2, 16'h0014);
        chk(16'(channel_pin_oe[3]), 16'h0000);
        rd(5'h0e, 8'h00);
        wr(5'h0b, 8'h18);
        duty(2, 16'h0000);
        wr(5'h0d, 8'h03);
        wr(5'h0b, 8'h1e);
        duty(2, 16'h000e);
        wr(5'h0e, 8'h04);
        gpio_level <= 4'h7;
        repeat (5) @(posedge clock);
        gpio_level <= 4'hf;
        repeat (6) @(posedge clock);
        rd(5'h0e, 8'h84);
        $display("pwm and capture done");
        break_active <= 1'b1;
        rd_get(5'h02, got);
        high_count = 16'(got);
        repeat (5) @(posedge clock);
        rd(5'h02, high_count[7:0]);
        wr(5'h00, 8'h60);
        break_active <= 1'b0;
        rd(5'h00, 8'he0);
        chk(16'(irq), 16'h0001);
        break_active <= 1'b1;
        wr(5'h00, 8'h60);
        rd(5'h00, 8'he0);
        break_active <= 1'b0;
        wr(5'h00, 8'h60);
        rd(5'h00, 8'h60);
        chk(16'(irq), 16'h0000);
        wr(5'h00, 8'h40);
        stop_mode <= 1'b1;
        rd_get(5'h02, got);
        high_count = 16'(got);
        repeat (5) @(posedge clock);
        rd(5'h02, high_count[7:0]);
        stop_mode <= 1'b0;
        wait_mode <= 1'b1;
        wr(5'h04, 8'h55);
        rd(5'h04, 8'h00);
        wait_mode <= 1'b0;
        rd(5'h04, 8'h09);
        $display("flags and modes done");
        wr(5'h03, 8'hff);
        wr(5'h04, 8'hff);
        for (int ps = 0; ps < 7; ps++)
        begin
            wr(5'h00, 8'h10 | 8'(ps));
            repeat (8 << ps) @(posedge clock);
            rd_get(5'h02, got);
            chk(16'(got >= 8'h07 && got <= 8'h0b), 16'h0001);
        end
        wr(5'h00, 8'h37);
        wr(5'h00, 8'h07);
        env.ext_pulses(5);
        repeat (6) @(posedge clock);
        rd(5'h02, 8'h05);
        chk(16'(external_clock_selected), 16'h0001);
        rd_get(5'h00, got);
        chk(16'(got[4:0]), 16'h0007);
        $display("prescale and external clock done");
        print_verdict();
    end
endmodule // tb
`default_nettype wire
